/* pifl_top.sv */
// pifl_top: peripheral interrupt flag and enable registers behind an APB3 slave.
// assumes: peripheral event pulses are synchronous to CLOCK; external pins are not.
// Functional notes
// - enables 2 holds RW bits 7,6,5 for capcomp 2, nvm, timer1 gate; reset zero.
// - no peripheral source interrupts unless the peripheral group enable is set.
// - flags 0 bit 5 sets on timer0 overflow and holds until software clears it.
// - flags 0 bit 4 is the OR of all per-pin change flags.
// - flags 0 bit 0 sets on an external event on the selected pin.
// - flags set on their events regardless of any enable bit.
// - flags 1 order ccp1,tmr2,tmr1,rx,tx,bcl,ssp,adc; serial bits read-only; other bits reset zero.
// - capcomp flags set on capture, match or pwm trailing edge per mode; sticky.
// - timer2, timer1, sync serial and converter flags are sticky until written clear.
// - rx flag at bit 4 is read-only and mirrors a non-empty receive buffer.
// - tx flag at bit 3 is read-only, high while the transmit buffer is empty.
// - bus collision flag at bit 2 sets on collision and holds until cleared.
// - flags 2 bit 6 sets when a nonvolatile operation finishes; sticky.
// - flags 2 bit 5 sets when the timer1 gate goes inactive; sticky.
// - enables 1 holds one enable bit per flags 1 bit, same order.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module pifl_top (
  input wire logic CLOCK, // system clock, 250 MHz
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic CE, // clock enable, low freezes all state
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [pifl_pkg::PIFL_ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [pifl_pkg::PIFL_DATA_W-1:0] PWDATA, // apb write data
  output logic [pifl_pkg::PIFL_DATA_W-1:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire pifl_pkg::pifl_events_t EVENTS, // peripheral events and levels
  input wire pifl_pkg::pifl_ccp_t CCP1, // capture/compare unit 1
  input wire pifl_pkg::pifl_ccp_t CCP2, // capture/compare unit 2
  input wire logic [pifl_pkg::PIFL_PCHG_W-1:0] PIN_CHANGE_FLAGS, // per-pin change flags
  input wire logic [pifl_pkg::PIFL_PIN_COUNT-1:0] EXT_PINS, // asynchronous pin levels
  input wire logic GATE_ACTIVE, // timer1 gate level, high while active
  output logic PERIPH_IRQ, // peripheral interrupt request to the core
  output logic GLOBAL_IRQ_EN // global enable bit for the core
);
  import pifl_pkg::*;

  logic [PIFL_REG_W-1:0] en_r [PIFL_FLAG_REGS];
  logic [PIFL_REG_W-1:0] core_r;
  logic [PIFL_PINSEL_W-1:0] pinsel_r;
  logic [PIFL_PIN_COUNT-1:0] pin_meta_r;
  logic [PIFL_PIN_COUNT-1:0] pin_sync_r;
  logic ext_prev_r;
  logic gate_prev_r;
  logic [PIFL_DATA_W-1:0] prdata_r;
  logic irq_r;
  logic irq_nxt;
  logic ext_cur;
  logic ext_event;
  logic gate_event;
  logic pin_change_any;
  logic rd_valid_r;
  logic wr_access;
  logic addr_mapped;
  logic [PIFL_REG_W-1:0] hw_set [PIFL_FLAG_REGS];
  logic [PIFL_REG_W-1:0] flag_q [PIFL_FLAG_REGS];
  logic [PIFL_REG_W-1:0] flag_view [PIFL_FLAG_REGS];
  logic [PIFL_REG_W-1:0] pend [PIFL_FLAG_REGS];
  logic [PIFL_FLAG_REGS-1:0] flag_wr;
  logic [PIFL_REG_W-1:0] rd_byte;

  // address hit test for one register index
  function automatic logic addr_hit(input logic [PIFL_ADDR_W-1:0] addr,
                                    input logic [PIFL_ADDR_W-1:0] idx);
    return addr == pifl_byte_addr(idx);
  endfunction

  // capture/compare event selected by the unit's mode
  function automatic logic ccp_event(input pifl_ccp_t u);
    logic ev;
    ev = 1'b0;
    case (u.mode)
      PIFL_CCP_CAPTURE: ev = u.capture;
      PIFL_CCP_COMPARE: ev = u.match;
      PIFL_CCP_PWM: ev = u.trail_edge;
      default: ev = 1'b0;
    endcase
    return ev;
  endfunction

  // apb write strobe, only while enabled
  assign wr_access = PSEL & PENABLE & PWRITE & CE;

  // address decode of every mapped register
  always_comb begin
    if (addr_hit(PADDR, PIFL_IDX_FLAGS0)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_FLAGS1)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_FLAGS2)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_EN0)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_EN1)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_EN2)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_CORE)) begin
      addr_mapped = 1'b1;
    end else if (addr_hit(PADDR, PIFL_IDX_PINSEL)) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  // write strobes to the flag registers
  assign flag_wr[0] = wr_access & addr_hit(PADDR, PIFL_IDX_FLAGS0);
  assign flag_wr[1] = wr_access & addr_hit(PADDR, PIFL_IDX_FLAGS1);
  assign flag_wr[2] = wr_access & addr_hit(PADDR, PIFL_IDX_FLAGS2);

  // two-stage synchroniser for the external pins
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (CE) begin
      pin_meta_r <= EXT_PINS;
      pin_sync_r <= pin_meta_r;
    end
  end

  // rising edge on the selected external pin
  assign ext_cur = pin_sync_r[pinsel_r];
  assign ext_event = ext_cur & ~ext_prev_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ext_prev_r <= 1'b0;
    end else if (CE) begin
      ext_prev_r <= ext_cur;
    end
  end

  // timer1 gate falling into the inactive state
  assign gate_event = gate_prev_r & ~GATE_ACTIVE;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      gate_prev_r <= 1'b0;
    end else if (CE) begin
      gate_prev_r <= GATE_ACTIVE;
    end
  end

  // hardware set vectors, independent of every enable
  always_comb begin
    for (int i = 0; i < PIFL_FLAG_REGS; i++) begin
      hw_set[i] = PIFL_REG_RESET;
    end
    hw_set[0][PIFL_F0_TMR0] = EVENTS.timer0_overflow;
    hw_set[0][PIFL_F0_EXT] = ext_event;
    hw_set[1][PIFL_F1_CCP1] = ccp_event(CCP1);
    hw_set[1][PIFL_F1_TMR2] = EVENTS.timer2_match;
    hw_set[1][PIFL_F1_TMR1] = EVENTS.timer1_overflow;
    hw_set[1][PIFL_F1_BCL] = EVENTS.bus_collision;
    hw_set[1][PIFL_F1_SSP] = EVENTS.sync_serial_done;
    hw_set[1][PIFL_F1_ADC] = EVENTS.converter_done;
    hw_set[2][PIFL_F2_CCP2] = ccp_event(CCP2);
    hw_set[2][PIFL_F2_NVM] = EVENTS.nonvolatile_done;
    hw_set[2][PIFL_F2_GATE] = gate_event;
  end

  // sticky flag cells where the mask marks a settable bit
  genvar gi;
  genvar gb;
  generate
    for (gi = 0; gi < PIFL_FLAG_REGS; gi++) begin : g_reg
      for (gb = 0; gb < PIFL_REG_W; gb++) begin : g_bit
        if (PIFL_STICKY_MASK[gi][gb]) begin : g_cell
          pifl_flag_cell u_cell (
            .clk(CLOCK),
            .rst(SYS_RST),
            .ce(CE),
            .set(hw_set[gi][gb]),
            .wr(flag_wr[gi]),
            .wr_val(PWDATA[gb]),
            .q(flag_q[gi][gb])
          );
        end else begin : g_none
          assign flag_q[gi][gb] = 1'b0;
        end
      end
    end
  endgenerate

  // summary of the per-pin change flags
  assign pin_change_any = |PIN_CHANGE_FLAGS;

  // software view of the flags, with the live read-only bits merged in
  always_comb begin
    for (int i = 0; i < PIFL_FLAG_REGS; i++) begin
      flag_view[i] = flag_q[i];
    end
    flag_view[0][PIFL_F0_PCHG] = pin_change_any;
    flag_view[1][PIFL_F1_RX] = EVENTS.rx_not_empty;
    flag_view[1][PIFL_F1_TX] = EVENTS.tx_buf_empty;
  end

  // enable registers, only implemented bits are kept
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      for (int i = 0; i < PIFL_FLAG_REGS; i++) begin
        en_r[i] <= PIFL_REG_RESET;
      end
    end else if (wr_access) begin
      if (addr_hit(PADDR, PIFL_IDX_EN0)) begin
        en_r[0] <= PWDATA[PIFL_REG_W-1:0] & PIFL_EN_MASK[0];
      end else if (addr_hit(PADDR, PIFL_IDX_EN1)) begin
        en_r[1] <= PWDATA[PIFL_REG_W-1:0] & PIFL_EN_MASK[1];
      end else if (addr_hit(PADDR, PIFL_IDX_EN2)) begin
        en_r[2] <= PWDATA[PIFL_REG_W-1:0] & PIFL_EN_MASK[2];
      end
    end
  end

  // core interrupt control and external pin select
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      core_r <= PIFL_REG_RESET;
      pinsel_r <= PIFL_PINSEL_RESET;
    end else if (wr_access) begin
      if (addr_hit(PADDR, PIFL_IDX_CORE)) begin
        core_r <= PWDATA[PIFL_REG_W-1:0] & PIFL_CORE_MASK;
      end else if (addr_hit(PADDR, PIFL_IDX_PINSEL)) begin
        pinsel_r <= PWDATA[PIFL_PINSEL_W-1:0];
      end
    end
  end

  // read data selection
  always_comb begin
    if (addr_hit(PADDR, PIFL_IDX_FLAGS0)) begin
      rd_byte = flag_view[0];
    end else if (addr_hit(PADDR, PIFL_IDX_FLAGS1)) begin
      rd_byte = flag_view[1];
    end else if (addr_hit(PADDR, PIFL_IDX_FLAGS2)) begin
      rd_byte = flag_view[2];
    end else if (addr_hit(PADDR, PIFL_IDX_EN0)) begin
      rd_byte = en_r[0];
    end else if (addr_hit(PADDR, PIFL_IDX_EN1)) begin
      rd_byte = en_r[1];
    end else if (addr_hit(PADDR, PIFL_IDX_EN2)) begin
      rd_byte = en_r[2];
    end else if (addr_hit(PADDR, PIFL_IDX_CORE)) begin
      rd_byte = core_r;
    end else if (addr_hit(PADDR, PIFL_IDX_PINSEL)) begin
      rd_byte = {{(PIFL_REG_W-PIFL_PINSEL_W){1'b0}}, pinsel_r};
    end else begin
      rd_byte = PIFL_REG_RESET;
    end
  end

  // read data held for the current read; a frozen setup edge costs one wait cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rd_valid_r <= 1'b0;
    end else if (CE) begin
      rd_valid_r <= PSEL & ~PWRITE & ~(PENABLE & rd_valid_r);
    end
  end

  // read data captured at the first enabled edge of a read, low byte only
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      prdata_r <= PIFL_RDATA_ZERO;
    end else if (CE && PSEL && !PWRITE && !rd_valid_r) begin
      prdata_r <= {{(PIFL_DATA_W-PIFL_REG_W){1'b0}}, rd_byte};
    end
  end

  // pending sources: flag and matching enable
  always_comb begin
    for (int i = 0; i < PIFL_FLAG_REGS; i++) begin
      pend[i] = flag_view[i] & en_r[i];
    end
  end

  // request gated by the peripheral group enable
  assign irq_nxt = core_r[PIFL_CORE_PERIPHERAL_GROUP_ENABLE] & (|pend[0] | |pend[1] | |pend[2]);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_r <= 1'b0;
    end else if (CE) begin
      irq_r <= irq_nxt;
    end
  end

  // outputs
  assign PRDATA = prdata_r;
  assign PREADY = CE & (PWRITE | rd_valid_r); // zero wait unless the setup edge was frozen
  assign PSLVERR = PSEL & PENABLE & ~addr_mapped;
  assign PERIPH_IRQ = irq_r;
  assign GLOBAL_IRQ_EN = core_r[PIFL_CORE_GIE];

endmodule // pifl_top

/* pifl_pkg.sv */
// pifl_pkg: constants, register indices, field positions and carrier types
// of the peripheral interrupt flag and enable block.
// assumes: 32-bit APB3 slave, byte address is four times a register index.
package pifl_pkg;

  localparam int PIFL_ADDR_W = 16;
  localparam int PIFL_DATA_W = 32;
  localparam int PIFL_REG_W = 8;
  localparam int PIFL_FLAG_REGS = 3;
  localparam int PIFL_PIN_COUNT = 8;
  localparam int PIFL_PINSEL_W = 3;
  localparam int PIFL_PCHG_W = 24;

  // register indices; byte address is index times four
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_FLAGS0 = 16'h070C;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_FLAGS1 = 16'h070D;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_FLAGS2 = 16'h070E;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_EN0 = 16'h0716;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_EN1 = 16'h0717;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_EN2 = 16'h0718;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_CORE = 16'h0720;
  localparam logic [PIFL_ADDR_W-1:0] PIFL_IDX_PINSEL = 16'h0721;

  // flag register 0 fields
  localparam int PIFL_F0_TMR0 = 5;
  localparam int PIFL_F0_PCHG = 4;
  localparam int PIFL_F0_EXT = 0;
  // flag register 1 fields
  localparam int PIFL_F1_CCP1 = 7;
  localparam int PIFL_F1_TMR2 = 6;
  localparam int PIFL_F1_TMR1 = 5;
  localparam int PIFL_F1_RX = 4;
  localparam int PIFL_F1_TX = 3;
  localparam int PIFL_F1_BCL = 2;
  localparam int PIFL_F1_SSP = 1;
  localparam int PIFL_F1_ADC = 0;
  // flag register 2 fields
  localparam int PIFL_F2_CCP2 = 7;
  localparam int PIFL_F2_NVM = 6;
  localparam int PIFL_F2_GATE = 5;
  // core interrupt control fields
  localparam int PIFL_CORE_GIE = 7;
  localparam int PIFL_CORE_PERIPHERAL_GROUP_ENABLE = 6;

  // hardware-settable, software-writable flag bits per flag register
  localparam logic [PIFL_REG_W-1:0] PIFL_STICKY_MASK [PIFL_FLAG_REGS] = '{8'h21, 8'hE7, 8'hE0};
  // implemented enable bits per enable register
  localparam logic [PIFL_REG_W-1:0] PIFL_EN_MASK [PIFL_FLAG_REGS] = '{8'h31, 8'hFF, 8'hE0};
  localparam logic [PIFL_REG_W-1:0] PIFL_CORE_MASK = 8'hC0;
  localparam logic [PIFL_REG_W-1:0] PIFL_REG_RESET = 8'h00;
  localparam logic [PIFL_PINSEL_W-1:0] PIFL_PINSEL_RESET = 3'h0;
  localparam logic [PIFL_DATA_W-1:0] PIFL_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PIFL_CCP_CAPTURE,
    PIFL_CCP_COMPARE,
    PIFL_CCP_PWM,
    PIFL_CCP_OFF
  } pifl_ccp_mode_t;

  // one capture/compare unit as seen by the flag logic
  typedef struct packed {
    pifl_ccp_mode_t mode;
    logic capture;
    logic match;
    logic trail_edge;
  } pifl_ccp_t;

  // single-cycle event pulses and status levels from the peripherals
  typedef struct packed {
    logic timer0_overflow;
    logic timer2_match;
    logic timer1_overflow;
    logic bus_collision;
    logic sync_serial_done;
    logic converter_done;
    logic nonvolatile_done;
    logic rx_not_empty;
    logic tx_buf_empty;
  } pifl_events_t;

  // byte address of a register index
  function automatic logic [PIFL_ADDR_W-1:0] pifl_byte_addr(input logic [PIFL_ADDR_W-1:0] idx);
    return {idx[PIFL_ADDR_W-3:0], 2'b00};
  endfunction

endpackage

/* pifl_flag_cell.sv */
// pifl_flag_cell: one sticky interrupt flag, set by hardware, written by software.
// assumes: set and write strobes are on the same clock; ce low freezes the flag.
`timescale 1ns/100ps
module pifl_flag_cell (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic set, // hardware event pulse
  input wire logic wr, // software write strobe
  input wire logic wr_val, // value written by software
  output logic q // flag state
);

  logic q_r;
  logic q_nxt;

  // set wins over a same-cycle software write
  always_comb begin
    if (set) begin
      q_nxt = 1'b1;
    end else if (wr) begin
      q_nxt = wr_val;
    end else begin
      q_nxt = q_r;
    end
  end

  // flag storage, reset to clear
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= 1'b0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule // pifl_flag_cell

/* pifl_top_sva.sv */
// pifl_chk: port-level assertions for the flag and enable block.
// assumes: bound to pifl_top, zero-wait APB, events on CLOCK.
`timescale 1ns/100ps
module pifl_chk (
  input wire logic CLOCK, // system clock
  input wire logic SYS_RST, // sync reset
  input wire logic CE, // clock enable
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access
  input wire logic PWRITE, // apb write
  input wire logic [pifl_pkg::PIFL_ADDR_W-1:0] PADDR, // byte address
  input wire logic [pifl_pkg::PIFL_DATA_W-1:0] PWDATA, // write data
  input wire logic [pifl_pkg::PIFL_DATA_W-1:0] PRDATA, // read data
  input wire logic PSLVERR, // apb error
  input wire pifl_pkg::pifl_events_t EVENTS, // peripheral events
  input wire logic [pifl_pkg::PIFL_PCHG_W-1:0] PIN_CHANGE_FLAGS, // pin flags
  input wire logic GATE_ACTIVE, // gate level
  input wire logic PERIPH_IRQ, // irq out
  input wire logic GLOBAL_IRQ_EN // global enable out
);
  import pifl_pkg::*;
  localparam logic [15:0] A_F0 = PIFL_IDX_FLAGS0 << 2;
  localparam logic [15:0] A_F1 = PIFL_IDX_FLAGS1 << 2;
  localparam logic [15:0] A_F2 = PIFL_IDX_FLAGS2 << 2;
  localparam logic [15:0] A_EN1 = PIFL_IDX_EN1 << 2;
  localparam logic [15:0] A_EN2 = PIFL_IDX_EN2 << 2;
  localparam logic [15:0] A_CORE = PIFL_IDX_CORE << 2;
  logic peripheral_group_enable_r, adc_en_r, wr, rd0, rd1, rd2, pchg_any, gie_wd;
  logic [1:0] ser_lvl;
  // apb decode and sampled levels
  assign wr = PSEL && PENABLE && PWRITE && CE;
  assign rd0 = PSEL && !PENABLE && !PWRITE && CE && PADDR == A_F0;
  assign rd1 = PSEL && !PENABLE && !PWRITE && CE && PADDR == A_F1;
  assign rd2 = PSEL && !PENABLE && !PWRITE && CE && PADDR == A_F2;
  assign pchg_any = |PIN_CHANGE_FLAGS;
  assign ser_lvl = {EVENTS.rx_not_empty, EVENTS.tx_buf_empty};
  assign gie_wd = PWDATA[7];
  // shadow copies of group enable and converter enable
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      peripheral_group_enable_r <= 1'b0;
      adc_en_r <= 1'b0;
    end else if (wr && PADDR == A_CORE) begin
      peripheral_group_enable_r <= PWDATA[6];
    end else if (wr && PADDR == A_EN1) begin
      adc_en_r <= PWDATA[0];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  irq_gated_a: assert property (!peripheral_group_enable_r && !$past(peripheral_group_enable_r) |-> !PERIPH_IRQ)
    else $error("irq without group enable");
  irq_raise_a: assert property (EVENTS.converter_done && CE && peripheral_group_enable_r && adc_en_r && !wr |-> ##2 PERIPH_IRQ)
    else $error("irq missing after enabled event");
  adc_sticky_a: assert property (EVENTS.converter_done && CE ##1 !wr ##1 rd1 |=> PRDATA[0])
    else $error("converter flag not set");
  tmr0_flag_a: assert property (EVENTS.timer0_overflow && CE ##1 !wr ##1 rd0 |=> PRDATA[5])
    else $error("timer0 flag not set");
  nvm_flag_a: assert property (EVENTS.nonvolatile_done && CE ##1 !wr ##1 rd2 |=> PRDATA[6])
    else $error("nvm flag not set");
  gate_flag_a: assert property ($fell(GATE_ACTIVE) && CE ##1 !wr ##1 rd2 |=> PRDATA[5])
    else $error("gate flag not set");
  serial_live_a: assert property (rd1 |=> PRDATA[4:3] == $past(ser_lvl))
    else $error("serial flags not live");
  pin_or_a: assert property (rd0 |=> PRDATA[4] == $past(pchg_any))
    else $error("pin change summary wrong");
  en2_bits_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == A_EN2 |-> (PRDATA & 32'hFFFF_FF1F) == 32'h0000_0000)
    else $error("enables 2 spare bits set");
  gie_out_a: assert property (wr && PADDR == A_CORE |=> GLOBAL_IRQ_EN == $past(gie_wd))
    else $error("global enable not updated");
  err_access_a: assert property (PSLVERR |-> PSEL && PENABLE && PADDR != A_F1 && PADDR != A_EN2 && PADDR != A_CORE)
    else $error("error outside access");
  ce_freeze_a: assert property (!CE |=> $stable(PRDATA) && $stable(PERIPH_IRQ) && $stable(GLOBAL_IRQ_EN))
    else $error("state moved with clock enable low");
endmodule // pifl_chk

bind pifl_top pifl_chk i_chk (.CLOCK, .SYS_RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PSLVERR,
  .EVENTS, .PIN_CHANGE_FLAGS, .GATE_ACTIVE, .PERIPH_IRQ, .GLOBAL_IRQ_EN);

/* pifl_periph_model.sv */
// pifl_periph_model: peripheral side, event pulses and status levels.
// assumes: tasks are called just after a rising clk edge.
`timescale 1ns/100ps
module pifl_periph_model (
  input wire logic clk, // system clock
  output pifl_pkg::pifl_events_t events, // pulses and levels
  output pifl_pkg::pifl_ccp_t ccp1, // capture/compare 1
  output pifl_pkg::pifl_ccp_t ccp2, // capture/compare 2
  output logic [pifl_pkg::PIFL_PCHG_W-1:0] pchg, // per-pin change flags
  output logic [pifl_pkg::PIFL_PIN_COUNT-1:0] pins, // external pins
  output logic gate // timer1 gate, high active
);
  import pifl_pkg::*;
  // quiet peripherals at time zero
  initial begin
    events = '0;
    ccp1 = '0;
    ccp2 = '0;
    pchg = '0;
    pins = '0;
    gate = 1'b0;
  end
  // one-cycle pulse on one event bit
  task automatic pulse_ev(input int i);
    events[i] <= 1'b1;
    @(posedge clk);
    events[i] <= 1'b0;
  endtask
  // strobe that suits the mode; off mode gets all three
  task automatic pulse_ccp(input int u, input pifl_ccp_mode_t m);
    pifl_ccp_t c;
    c.mode = m;
    c.capture = (m == PIFL_CCP_CAPTURE || m == PIFL_CCP_OFF);
    c.match = (m == PIFL_CCP_COMPARE || m == PIFL_CCP_OFF);
    c.trail_edge = (m == PIFL_CCP_PWM || m == PIFL_CCP_OFF);
    if (u == 1) ccp1 <= c;
    else ccp2 <= c;
    @(posedge clk);
    if (u == 1) ccp1 <= {m, 3'h0};
    else ccp2 <= {m, 3'h0};
  endtask
  // status levels
  task automatic levels(input logic rx, input logic tx, input logic g, input logic [23:0] pc, input logic [7:0] p);
    events.rx_not_empty <= rx;
    events.tx_buf_empty <= tx;
    gate <= g;
    pchg <= pc;
    pins <= p;
  endtask
endmodule // pifl_periph_model

/* testbench.sv */
// testbench: register, flag and interrupt scenarios for pifl_top.
// assumes: pifl_chk is bound in, peripheral model drives events.
`timescale 1ns/100ps
module testbench;
  import pifl_pkg::*;
  localparam logic [15:0] A_F0 = PIFL_IDX_FLAGS0 << 2;
  localparam logic [15:0] A_F1 = PIFL_IDX_FLAGS1 << 2;
  localparam logic [15:0] A_F2 = PIFL_IDX_FLAGS2 << 2;
  localparam logic [15:0] A_EN0 = PIFL_IDX_EN0 << 2;
  localparam logic [15:0] A_EN1 = PIFL_IDX_EN1 << 2;
  localparam logic [15:0] A_EN2 = PIFL_IDX_EN2 << 2;
  localparam logic [15:0] A_CORE = PIFL_IDX_CORE << 2;
  localparam logic [15:0] A_PSEL = PIFL_IDX_PINSEL << 2;
  logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, irq, global_irq_enable, gate, last_err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  pifl_events_t ev;
  pifl_ccp_t c1, c2;
  logic [23:0] pchg;
  logic [7:0] pins;
  int bad_count = 0, total_checks = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  pifl_top i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVENTS(ev),
    .CCP1(c1), .CCP2(c2), .PIN_CHANGE_FLAGS(pchg), .EXT_PINS(pins), .GATE_ACTIVE(gate), .PERIPH_IRQ(irq),
    .GLOBAL_IRQ_EN(global_irq_enable));
  pifl_periph_model i_model (.clk(clock), .events(ev), .ccp1(c1), .ccp2(c2), .pchg(pchg), .pins(pins), .gate(gate));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r, exp);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    rd_chk(A_F1, 32'h0000_0000);
    i_model.levels(1'b1, 1'b1, 1'b0, 24'h00_0000, 8'h00);
    wr(A_F1, 8'h00);
    rd_chk(A_F1, 32'h0000_0018);
    rd_chk(A_EN2, 32'h0000_0000);
    wr(A_EN2, 8'hFF);
    rd_chk(A_EN2, 32'h0000_00E0);
    wr(A_EN1, 8'hFF);
    rd_chk(A_EN1, 32'h0000_00FF);
    wr(A_EN0, 8'hFF);
    rd_chk(A_EN0, 32'h0000_0031);
    wr(A_EN0, 8'h00);
    wr(A_EN1, 8'h00);
    wr(A_EN2, 8'h00);
    apb(1'b0, 16'h1C40, 8'h00, r);
    chk(r, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
    i_model.levels(1'b0, 1'b0, 1'b0, 24'h00_0000, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_sticky();
    int ev_i[7] = '{8, 7, 6, 5, 4, 3, 2};
    logic [15:0] ad[7] = '{A_F0, A_F1, A_F1, A_F1, A_F1, A_F1, A_F2};
    int bt[7] = '{5, 6, 5, 2, 1, 0, 6};
    for (int k = 0; k < 7; k++) begin
      i_model.pulse_ev(ev_i[k]);
      rd_chk(ad[k], 32'h0000_0001 << bt[k]);
      wr(ad[k], 8'h00);
      rd_chk(ad[k], 32'h0000_0000);
    end
    fork
      wr(A_F1, 8'h00);
      begin
        repeat (2) @(posedge clock);
        i_model.pulse_ev(3);
      end
    join
    rd_chk(A_F1, 32'h0000_0001);
    wr(A_F1, 8'h00);
    $display("test sticky done");
  endtask
  task automatic t_ccp();
    for (int u = 1; u <= 2; u++) begin
      for (int m = 0; m < 4; m++) begin
        i_model.pulse_ccp(u, pifl_ccp_mode_t'(m));
        rd_chk(u == 1 ? A_F1 : A_F2, m == 3 ? 32'h0000_0000 : 32'h0000_0080);
        wr(u == 1 ? A_F1 : A_F2, 8'h00);
      end
    end
    $display("test ccp done");
  endtask
  task automatic t_pins();
    i_model.levels(1'b0, 1'b0, 1'b1, 24'h02_0000, 8'h00);
    @(posedge clock);
    rd_chk(A_F2, 32'h0000_0000);
    wr(A_F0, 8'h00);
    rd_chk(A_F0, 32'h0000_0010);
    i_model.levels(1'b0, 1'b0, 1'b0, 24'h00_0000, 8'h00);
    @(posedge clock);
    rd_chk(A_F2, 32'h0000_0020);
    rd_chk(A_F0, 32'h0000_0000);
    wr(A_F2, 8'h00);
    wr(A_PSEL, 8'h03);
    rd_chk(A_PSEL, 32'h0000_0003);
    wr(A_F0, 8'h00);
    i_model.levels(1'b0, 1'b0, 1'b0, 24'h00_0000, 8'h20);
    repeat (5) @(posedge clock);
    rd_chk(A_F0, 32'h0000_0000);
    i_model.levels(1'b0, 1'b0, 1'b0, 24'h00_0000, 8'h08);
    repeat (5) @(posedge clock);
    rd_chk(A_F0, 32'h0000_0001);
    wr(A_F0, 8'h00);
    $display("test pins done");
  endtask
  task automatic t_irq();
    for (int k = 0; k < 2; k++) begin
      wr(A_CORE, 8'hC0);
      wr(k ? A_F2 : A_F1, 8'h00);
      wr(k ? A_EN2 : A_EN1, k ? 8'h40 : 8'h01);
      repeat (2) @(negedge clock);
      chk({31'h0, irq}, 32'h0000_0000);
      @(posedge clock);
      i_model.pulse_ev(k ? 2 : 3);
      repeat (2) @(negedge clock);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(A_CORE, 8'h80);
      repeat (2) @(negedge clock);
      chk({31'h0, irq}, 32'h0000_0000);
      chk({31'h0, global_irq_enable}, 32'h0000_0001);
      wr(k ? A_F2 : A_F1, 8'h00);
      wr(k ? A_EN2 : A_EN1, 8'h00);
    end
    $display("test irq done");
  endtask
  // clock enable low over a read setup edge and an event: both frozen
  task automatic t_ce();
    fork
      rd_chk(A_F1, 32'h0000_0000);
      begin
        @(posedge clock);
        ce <= 1'b0;
        i_model.pulse_ev(3);
        @(negedge clock);
        chk({31'h0, pready}, 32'h0000_0000);
        @(posedge clock);
        ce <= 1'b1;
      end
    join
    $display("test ce done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_sticky();
    t_ccp();
    t_pins();
    t_irq();
    t_ce();
    report_and_stop();
  end
endmodule // testbench
